//--- rtl/adcss_seq.sv
// Scan sequencer, result store and serial register port of the ADC
`timescale 1ns/1ps
// How it works
// - 8-bit: lower register holds result, upper hidden
// - 8-bit reads advance to next enabled lower
// - 10-bit: two msbs upper, eight lsbs lower
// - 10-bit reads go upper, lower, next channel
// - Valid/overrun flags at upper bits seven/six
// - Valid sets on conversion, clears on read/config
// - Start pointer write keeps valid flags
// - Overrun on repeat conversion in modes one, three
// - Reset idle; idle aborts, releases interrupt pin
// - Idle stops converter clock and oscillator
// - Single mode: run write converts pointed channel
// - Single done: flags, pin, oscillator stop
// - Single mode read clears flag, starts next
// - Single scan converts enabled, ascending, wrapping, until all enabled valid
// - Scan: converting flag drops between channels
// - Scan end: interrupt, complete flag, oscillator off
// - Zero start write stops after current channel
// - Continuous scan wraps through enabled channels forever
// - Continuous: complete after pass, interrupt held off
// - Config writes, run/load writes, data reads abort
// - Enable bit per channel; disabled ones skipped
// - Load bit loads pointer from channel field
// - Complete flag clears on data read or config write
module adcss_seq (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire adcss_pkg::adcss_spi_in_t spi_in,
  output logic miso_q,
  output logic miso_oe_q,
  output logic irq_n_q,
  output logic irq_n_oe_q,
  output adcss_pkg::adcss_conv_req_t conv_req_q,
  input wire adcss_pkg::adcss_conv_rsp_t conv_rsp,
  output logic conv_clk_en_q,
  output logic osc_on_q
);
  import adcss_pkg::*;

  adcss_state_t s_q;
  adcss_state_t s_d;
  logic ce_s;
  logic sck_rise;
  logic byte_done;
  logic [7:0] rx_byte;
  logic wr_ev;
  logic ld_ev;
  logic rd_ev;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_data;
  logic done_ev;
  adcss_start_t wr_start;

  // Next enabled channel above p, wrapping; p itself if none
  function automatic logic [2:0] next_chan(input logic [2:0] p,
                                           input logic [NCH-1:0] en);
    logic [2:0] c;
    logic found;
    c = p;
    found = 1'b0;
    next_chan = p;
    for (int i = 1; i < NCH; i++) begin
      c = p + 3'(i);
      if (!found && en[c]) begin
        next_chan = c;
        found = 1'b1;
      end
    end
  endfunction

  // Serial frame decode from the synchronised pins
  assign ce_s = s_q.sync2.ce;
  assign sck_rise = ce_s && s_q.sync2.sck && !s_q.sck_prev;
  assign byte_done = sck_rise && (s_q.bitcnt == BIT_LAST);
  assign rx_byte = {s_q.shin[6:0], s_q.sync2.mosi};
  assign wr_ev = byte_done && s_q.cmd_valid && s_q.cmd_write;
  // A read byte is loaded at the end of the byte before it but counts as
  // read only at its own first sck rise; a prefetch that ce cuts off
  // leaves flags, pointer and conversions alone
  assign ld_ev = byte_done && (s_q.cmd_valid ? !s_q.cmd_write
                                             : !rx_byte[CMD_WRITE_BIT]);
  assign rd_ev = sck_rise && s_q.cmd_valid && !s_q.cmd_write &&
                 (s_q.bitcnt == '0);
  assign rd_addr = s_q.cmd_valid ? s_q.addr : rx_byte[ADDR_W-1:0];
  assign rd_data = rd_ev && (s_q.addr <= ADDR_DATA_MAX);
  assign done_ev = (s_q.seq == SEQ_CONV) && conv_rsp.done;
  assign wr_start = adcss_start_t'(rx_byte);

  // Whole next state of the block
  always_comb begin
    logic [7:0] rd_val;
    logic [2:0] ch;
    logic all_done;
    logic abort;
    logic start;
    logic [2:0] start_ch;
    adcss_upper_t up;
    adcss_status_t st;
    rd_val = 8'h00;
    ch = s_q.conv_ch;
    all_done = 1'b0;
    abort = 1'b0;
    start = 1'b0;
    start_ch = s_q.channel_pointer;
    up = '0;
    st = '0;
    s_d = s_q;
    s_d.conv_req.start = 1'b0;
    s_d.conv_req.abort = 1'b0;
    // Two flip-flops on every pin before use
    s_d.sync1 = spi_in;
    s_d.sync2 = s_q.sync1;
    s_d.sck_prev = s_q.sync2.sck;

    // Value of the register being read
    up.result_valid_flag = s_q.result_valid_flag[s_q.channel_pointer];
    up.overrun_flag = s_q.overrun_flag[s_q.channel_pointer];
    up.msb = s_q.result[s_q.channel_pointer][RES_W-1:8];
    st.int_flag = s_q.int_flag;
    st.scan_complete_flag = s_q.scan_complete_flag;
    st.converting_flag = (s_q.seq == SEQ_CONV);
    st.channel_pointer = s_q.channel_pointer;
    if (rd_addr <= ADDR_DATA_MAX) begin
      if (s_q.mode_select_reg.ten_bit && !s_q.lower_sel) begin
        rd_val = up;
      end else begin
        rd_val = s_q.result[s_q.channel_pointer][7:0];
      end
    end else begin
      case (rd_addr)
        ADDR_MODE: rd_val = s_q.mode_select_reg;
        ADDR_CHAN: rd_val = s_q.channel_enable_reg;
        ADDR_START: rd_val = {s_q.start_pointer_reg[7:1], s_q.lower_sel};
        ADDR_STATUS: rd_val = st;
        default: rd_val = 8'h00;
      endcase
    end

    // Shift engine: sample on rise, load or shift out after it
    if (!ce_s) begin
      s_d.bitcnt = 3'h0;
      s_d.cmd_valid = 1'b0;
    end else if (sck_rise) begin
      s_d.shin = rx_byte;
      s_d.bitcnt = s_q.bitcnt + 3'h1;
      s_d.shout = {s_q.shout[6:0], 1'b0};
      if (byte_done && !s_q.cmd_valid) begin
        s_d.cmd_valid = 1'b1;
        s_d.cmd_write = rx_byte[CMD_WRITE_BIT];
        s_d.addr = rx_byte[ADDR_W-1:0];
      end
      if (ld_ev) begin
        s_d.shout = rd_val;
      end
    end

    // Host clears of flags come before hardware sets
    if (wr_ev && (s_q.addr == ADDR_MODE || s_q.addr == ADDR_CHAN)) begin
      s_d.result_valid_flag = '0;
      s_d.overrun_flag = '0;
      s_d.int_flag = 1'b0;
      s_d.scan_complete_flag = 1'b0;
      if (s_q.addr == ADDR_MODE) begin
        s_d.mode_select_reg = adcss_mode_t'(rx_byte);
      end else begin
        s_d.channel_enable_reg = rx_byte;
      end
      abort = 1'b1;
    end
    if (rd_ev && s_q.addr == ADDR_STATUS) begin
      s_d.int_flag = 1'b0;
    end
    if (rd_data) begin
      s_d.result_valid_flag[s_q.channel_pointer] = 1'b0;
      s_d.overrun_flag[s_q.channel_pointer] = 1'b0;
      s_d.int_flag = 1'b0;
      s_d.scan_complete_flag = 1'b0;
      abort = 1'b1;
      if (s_q.mode_select_reg.ten_bit && !s_q.lower_sel) begin
        s_d.lower_sel = 1'b1;
      end else begin
        s_d.lower_sel = 1'b0;
        s_d.channel_pointer = next_chan(s_q.channel_pointer,
                                        s_q.channel_enable_reg);
        if (s_q.mode_select_reg.mode == OP_SINGLE) begin
          start = 1'b1;
          start_ch = s_d.channel_pointer;
        end
      end
    end

    // Conversion finished: store, set flags, pick next step
    if (done_ev) begin
      s_d.result[ch] = conv_rsp.data;
      if (s_q.result_valid_flag[ch] &&
          (s_q.mode_select_reg.mode == OP_SINGLE ||
           s_q.mode_select_reg.mode == OP_CONT)) begin
        s_d.overrun_flag[ch] = 1'b1;
      end
      s_d.result_valid_flag[ch] = 1'b1;
      all_done = (s_d.result_valid_flag & s_q.channel_enable_reg) ==
                 s_q.channel_enable_reg;
      s_d.seq = SEQ_IDLE;
      case (s_q.mode_select_reg.mode)
        OP_SINGLE: begin
          s_d.int_flag = 1'b1;
          s_d.scan_complete_flag = s_d.scan_complete_flag | all_done;
        end
        OP_SCAN: begin
          if (s_q.run_bit) begin
            s_d.channel_pointer = next_chan(s_q.channel_pointer,
                                            s_q.channel_enable_reg);
            if (all_done) begin
              s_d.int_flag = 1'b1;
              s_d.scan_complete_flag = 1'b1;
              s_d.run_bit = 1'b0;
            end else begin
              s_d.seq = SEQ_GAP;
            end
          end
        end
        OP_CONT: begin
          if (all_done) begin
            s_d.scan_complete_flag = 1'b1;
          end
          if (s_q.run_bit) begin
            s_d.channel_pointer = next_chan(s_q.channel_pointer,
                                            s_q.channel_enable_reg);
            s_d.seq = SEQ_GAP;
          end
        end
        default: s_d.seq = SEQ_IDLE;
      endcase
    end else if (s_q.seq == SEQ_GAP && !abort) begin
      start = 1'b1;
      start_ch = s_q.channel_pointer;
    end

    // Start pointer write: load, run, abort, stop
    if (wr_ev && s_q.addr == ADDR_START) begin
      s_d.start_pointer_reg = wr_start;
      s_d.run_bit = wr_start.run_bit;
      // A stop may land in the gap: no further channel after it
      if (!wr_start.run_bit) begin
        start = 1'b0;
        if (s_d.seq == SEQ_GAP) begin
          s_d.seq = SEQ_IDLE;
        end
      end
      if (wr_start.pointer_load_bit) begin
        s_d.channel_pointer = wr_start.pointer_field;
        s_d.lower_sel = wr_start.lower_sel;
      end
      if (wr_start.run_bit || wr_start.pointer_load_bit) begin
        abort = 1'b1;
      end
      if (wr_start.run_bit &&
          s_q.mode_select_reg.mode != OP_IDLE) begin
        start = 1'b1;
        start_ch = s_d.channel_pointer;
      end
    end

    // Idle mode cancels any run
    if (s_d.mode_select_reg.mode == OP_IDLE) begin
      s_d.run_bit = 1'b0;
      abort = 1'b1;
      start = 1'b0;
    end

    // Sequencer moves decided by host actions win
    if (abort) begin
      s_d.seq = SEQ_IDLE;
      s_d.conv_req.abort = (s_q.seq != SEQ_IDLE);
    end
    if (start) begin
      s_d.seq = SEQ_CONV;
      s_d.conv_ch = start_ch;
      s_d.conv_req.start = 1'b1;
      s_d.conv_req.channel = start_ch;
    end
    s_d.conv_req.ten_bit = s_d.mode_select_reg.ten_bit;

    // Pin and clock outputs from the next state, miso_oe from the current one
    s_d.miso = s_d.shout[7];
    s_d.miso_oe = ce_s && s_q.cmd_valid && !s_q.cmd_write;
    s_d.irq_oe = s_d.int_flag && s_d.mode_select_reg.irq_pin_enable &&
                 (s_d.mode_select_reg.mode == OP_SINGLE ||
                  s_d.mode_select_reg.mode == OP_SCAN);
    s_d.clk_en = (s_d.seq != SEQ_IDLE);
    s_d.osc_on = s_d.clk_en &&
                 s_d.mode_select_reg.oscillator_select;
  end

  // State register with synchronous reset to idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops, except irq_n_q which is tied low
  assign miso_q = s_q.miso;
  assign miso_oe_q = s_q.miso_oe;
  assign irq_n_q = 1'b0; // Open drain: low whenever enabled
  assign irq_n_oe_q = s_q.irq_oe;
  assign conv_req_q = s_q.conv_req;
  assign conv_clk_en_q = s_q.clk_en;
  assign osc_on_q = s_q.osc_on;

  // Checks of sequencing and flag behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_idle_no_clock: assert property (
    s_q.mode_select_reg.mode == OP_IDLE |-> !s_q.clk_en && !s_q.osc_on)
    else $error("clock runs in idle");
  a_idle_irq_free: assert property (
    s_q.mode_select_reg.mode == OP_IDLE |-> !s_q.irq_oe)
    else $error("interrupt pin driven in idle");
  a_done_sets_valid: assert property (
    done_ev && !rd_data |=> s_q.result_valid_flag[$past(s_q.conv_ch)])
    else $error("valid flag not set on conversion");
  a_single_done_int: assert property (
    done_ev && s_q.mode_select_reg.mode == OP_SINGLE && !wr_ev && !rd_ev
    |=> s_q.int_flag && s_q.seq == SEQ_IDLE && !s_q.osc_on)
    else $error("single conversion end wrong");
  a_read_restarts: assert property (
    rd_data && s_q.seq == SEQ_IDLE && !s_q.lower_sel &&
    !s_q.mode_select_reg.ten_bit &&
    s_q.mode_select_reg.mode == OP_SINGLE
    |=> !s_q.int_flag && s_q.seq == SEQ_CONV && s_q.conv_req.start)
    else $error("single read did not restart");
  a_cont_int_off: assert property (
    s_q.mode_select_reg.mode == OP_CONT |-> !s_q.int_flag && !s_q.irq_oe)
    else $error("interrupt active in continuous scan");
  a_start_keeps_valid: assert property (
    wr_ev && s_q.addr == ADDR_START && !done_ev
    |=> s_q.result_valid_flag == $past(s_q.result_valid_flag))
    else $error("start write changed valid flags");
  a_gap_restarts: assert property (
    s_q.seq == SEQ_GAP && !wr_ev && !rd_ev
    |=> s_q.seq == SEQ_CONV ##0 s_q.conv_req.start)
    else $error("gap not followed by conversion");
  a_stop_after_run: assert property (
    done_ev && !s_q.run_bit && !wr_ev && !rd_ev |=> s_q.seq == SEQ_IDLE
    ##1 s_q.seq == SEQ_IDLE [*3])
    else $error("conversion continued after stop");
  a_byte_advance: assert property (
    rd_data && !s_q.mode_select_reg.ten_bit && !done_ev
    |=> !s_q.lower_sel && s_q.channel_pointer ==
        next_chan($past(s_q.channel_pointer), s_q.channel_enable_reg))
    else $error("8-bit read pointer advance wrong");

  c_single_done: cover property (
    done_ev && s_q.mode_select_reg.mode == OP_SINGLE);
  c_scan_complete: cover property (
    s_q.mode_select_reg.mode == OP_SCAN && !s_q.scan_complete_flag
    ##1 s_q.scan_complete_flag);
  c_cont_wrap: cover property (
    s_q.mode_select_reg.mode == OP_CONT && s_q.seq == SEQ_GAP);
  c_data_read: cover property (rd_data);
endmodule // adcss_seq

//--- common/adcss_pkg.sv
// Register map, field layouts and state types of the ADC scan sequencer
package adcss_pkg;
  localparam int NCH = 8;
  localparam int ADDR_W = 7;
  localparam int CMD_WRITE_BIT = 7;
  localparam int RES_W = 10;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_DATA_MAX = 7'h0F;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 7'h10;
  localparam logic [ADDR_W-1:0] ADDR_CHAN = 7'h11;
  localparam logic [ADDR_W-1:0] ADDR_START = 7'h12;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h13;

  typedef enum logic [1:0] {
    OP_IDLE = 2'h0, OP_SINGLE = 2'h1, OP_SCAN = 2'h2, OP_CONT = 2'h3
  } adcss_op_t;

  // Sequencer states, Gray coded along idle, convert, gap
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0, SEQ_CONV = 2'h1, SEQ_GAP = 2'h3
  } adcss_seq_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic oscillator_select;
    logic irq_pin_enable;
    logic ten_bit;
    adcss_op_t mode;
  } adcss_mode_t;

  typedef struct packed {
    logic run_bit;
    logic [1:0] rsvd;
    logic pointer_load_bit;
    logic [2:0] pointer_field;
    logic lower_sel;
  } adcss_start_t;

  typedef struct packed {
    logic int_flag;
    logic scan_complete_flag;
    logic converting_flag;
    logic zero_hi;
    logic [2:0] channel_pointer;
    logic zero_lo;
  } adcss_status_t;

  typedef struct packed {
    logic result_valid_flag;
    logic overrun_flag;
    logic [3:0] zero;
    logic [1:0] msb;
  } adcss_upper_t;

  typedef struct packed {
    logic ce;
    logic sck;
    logic mosi;
  } adcss_spi_in_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic [2:0] channel;
    logic ten_bit;
  } adcss_conv_req_t;

  typedef struct packed {
    logic done;
    logic [RES_W-1:0] data;
  } adcss_conv_rsp_t;

  typedef struct packed {
    adcss_spi_in_t sync1;
    adcss_spi_in_t sync2;
    logic sck_prev;
    logic [2:0] bitcnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic cmd_valid;
    logic cmd_write;
    logic [ADDR_W-1:0] addr;
    adcss_mode_t mode_select_reg;
    logic [NCH-1:0] channel_enable_reg;
    adcss_start_t start_pointer_reg;
    logic [2:0] channel_pointer;
    logic lower_sel;
    logic [NCH-1:0][RES_W-1:0] result;
    logic [NCH-1:0] result_valid_flag;
    logic [NCH-1:0] overrun_flag;
    logic int_flag;
    logic scan_complete_flag;
    logic run_bit;
    adcss_seq_t seq;
    logic [2:0] conv_ch;
    adcss_conv_req_t conv_req;
    logic irq_oe;
    logic miso;
    logic miso_oe;
    logic clk_en;
    logic osc_on;
  } adcss_state_t;

  localparam adcss_state_t ST_RESET = '0;
endpackage

//--- tb/adcss_host_model.sv
// Host side of the serial link: frames, command byte, data bytes
`timescale 1ns/1ps
module adcss_host_model (
  input wire logic ref_clk,
  input wire logic miso_q,
  input wire logic miso_oe_q,
  output adcss_pkg::adcss_spi_in_t spi_in
);
  import adcss_pkg::*;
  logic [7:0] rx [8];

  // Link idles with ce low and sck low
  initial spi_in = '0;

  // One byte, msb first; miso is taken just before each sck rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] got);
    for (int b = 7; b >= 0; b--) begin
      spi_in.mosi = tx[b];
      #62.5;
      // A released line reads back inverted so a missing enable shows
      got[b] = miso_oe_q ? miso_q : ~miso_q;
      spi_in.sck = 1'b1;
      #62.5;
      spi_in.sck = 1'b0;
    end
  endtask

  // Command byte then n data bytes; write data repeats wd
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd,
                       input int n);
    logic [7:0] junk;
    @(negedge ref_clk);
    spi_in.ce = 1'b1;
    #62.5;
    shift(cmd, junk);
    for (int k = 0; k < n; k++) shift(wd, rx[k]);
    #62.5;
    spi_in.ce = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule // adcss_host_model

//--- tb/adcss_seq_tb.sv
// Self-checking bench of the scan sequencer with a converter stand-in
`timescale 1ns/1ps
module adcss_seq_tb;
  import adcss_pkg::*;
  logic ref_clk;
  logic rst_n;
  adcss_spi_in_t spi_in;
  logic miso_q;
  logic miso_oe_q;
  logic irq_n_oe_q;
  adcss_conv_req_t conv_req_q;
  adcss_conv_rsp_t conv_rsp;
  logic conv_clk_en_q;
  logic osc_on_q;
  int bad_count = 0;
  int checks_done = 0;
  int lat = 20;
  int cnt = 0;
  int n;
  logic [2:0] cch;
  logic [9:0] rv;
  logic [7:0] pins;
  logic [2:0] seen[$];

  adcss_seq i_adcss_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .spi_in(spi_in),
    .miso_q(miso_q),
    .miso_oe_q(miso_oe_q),
    .irq_n_q(),
    .irq_n_oe_q(irq_n_oe_q),
    .conv_req_q(conv_req_q),
    .conv_rsp(conv_rsp),
    .conv_clk_en_q(conv_clk_en_q),
    .osc_on_q(osc_on_q)
  );
  adcss_host_model i_adcss_host_model (
    .ref_clk(ref_clk),
    .miso_q(miso_q),
    .miso_oe_q(miso_oe_q),
    .spi_in(spi_in)
  );

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Result pattern of each channel
  function automatic logic [9:0] res10(input logic [2:0] c);
    return {c[1:0], 5'h15, c};
  endfunction
  function automatic logic [7:0] lo(input logic [2:0] c);
    logic [9:0] r;
    r = res10(c);
    return r[7:0];
  endfunction
  function automatic logic [7:0] up(input logic [2:0] c, input logic [1:0] f);
    logic [9:0] r;
    r = res10(c);
    return {f, 4'h0, r[9:8]};
  endfunction
  function automatic logic [7:0] rx(input int k);
    return i_adcss_host_model.rx[k];
  endfunction

  // Converter stand-in: answers a start after lat cycles, drops on abort
  initial conv_rsp = '0;
  always @(negedge ref_clk) begin
    conv_rsp.done <= 1'b0;
    if (conv_req_q.start === 1'b1) begin
      cnt = lat;
      cch = conv_req_q.channel;
      seen.push_back(cch);
    end else if (conv_req_q.abort === 1'b1) begin
      cnt = 0;
    end else if (cnt == 1) begin
      cnt = 0;
      rv = res10(cch);
      conv_rsp.done <= 1'b1;
      conv_rsp.data <= conv_req_q.ten_bit ? rv : {2'h0, rv[7:0]};
    end else if (cnt > 1) begin
      cnt--;
    end
  end

  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen_v,
                       input logic [7:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp_v, seen_v);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    i_adcss_host_model.frame({1'b1, a}, d, 1);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input int k);
    i_adcss_host_model.frame({1'b0, a}, 8'h00, k);
  endtask

  // Bounded polls of the status register and of the interrupt pin
  task automatic wait_status(input logic [7:0] m);
    for (int k = 0; k < 60; k++) begin
      rd(ADDR_STATUS, 1);
      if ((rx(0) & m) != 8'h00) return;
    end
    check("status wait", 8'h00, 8'h01);
    conclude();
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 4000; k++) begin
      @(negedge ref_clk);
      if (irq_n_oe_q === 1'b1) return;
    end
    check("irq wait", 8'h00, 8'h01);
    conclude();
  endtask

  task automatic t_reset();
    rd(ADDR_STATUS, 1);
    check("status reset", rx(0), 8'h00);
    rd(ADDR_MODE, 1);
    check("mode reset", rx(0), 8'h00);
    pins = {5'h0, conv_clk_en_q, osc_on_q, irq_n_oe_q};
    check("idle pins", pins, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rd(7'h20, 1);
    check("unmapped", rx(0), 8'h00);
    rd(ADDR_STATUS, 1);
    check("status kept", rx(0), 8'h00);
  endtask

  task automatic t_scan();
    wr(ADDR_MODE, 8'h0E);
    wr(ADDR_CHAN, 8'h24);
    seen.delete();
    wr(ADDR_START, 8'h9A);
    wait_irq();
    check("scan count", 8'(seen.size()), 8'h02);
    check("scan first", {5'h0, seen[0]}, 8'h05);
    check("scan wrap", {5'h0, seen[1]}, 8'h02);
    rd(ADDR_STATUS, 1);
    check("scan end", rx(0), 8'hCA);
    check("scan clk", {7'h0, conv_clk_en_q}, 8'h00);
    wr(ADDR_START, 8'h1A);
    rd(7'h0A, 1);
    check("upper", rx(0), up(3'h5, 2'h2));
    check("irq off", {7'h0, irq_n_oe_q}, 8'h00);
    seen.delete();
    wr(ADDR_START, 8'h9A);
    wait_irq();
    check("restart", 8'(seen.size()), 8'h01);
    wr(ADDR_START, 8'h1A);
    rd(7'h0A, 4);
    check("upper5", rx(0), up(3'h5, 2'h2));
    check("lower5", rx(1), lo(3'h5));
    check("upper2", rx(2), up(3'h2, 2'h2));
    check("lower2", rx(3), lo(3'h2));
    wr(ADDR_START, 8'h1A);
    rd(7'h0A, 1);
    check("valid clr", rx(0), up(3'h5, 2'h0));
    rd(ADDR_STATUS, 1);
    check("acc clr", rx(0) & 8'h40, 8'h00);
  endtask

  task automatic t_single();
    lat = 600;
    wr(ADDR_MODE, 8'h11);
    wr(ADDR_CHAN, 8'h03);
    seen.delete();
    wr(ADDR_START, 8'h96);
    check("osc on", {6'h0, osc_on_q, conv_clk_en_q}, 8'h03);
    rd(ADDR_STATUS, 1);
    check("converting", rx(0) & 8'hE0, 8'h20);
    wait_status(8'h80);
    check("single end", rx(0) & 8'hE0, 8'h80);
    check("osc off", {7'h0, osc_on_q}, 8'h00);
    rd(7'h07, 1);
    check("8-bit", rx(0), lo(3'h3));
    check("next ch", {5'h0, seen[1]}, 8'h00);
    check("one restart", 8'(seen.size()), 8'h02);
    wr(ADDR_MODE, 8'h00);
    check("abort", {6'h0, osc_on_q, conv_clk_en_q}, 8'h00);
    wr(ADDR_CHAN, 8'h28);
    wr(ADDR_START, 8'h16);
    rd(7'h07, 2);
    check("multi 3", rx(0), lo(3'h3));
    check("multi 5", rx(1), lo(3'h5));
  endtask

  task automatic t_overrun();
    lat = 20;
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_CHAN, 8'h01);
    wr(ADDR_START, 8'h90);
    wait_status(8'h80);
    wr(ADDR_START, 8'h90);
    wait_status(8'h80);
    wr(ADDR_START, 8'h10);
    rd(7'h00, 1);
    check("overrun", rx(0), up(3'h0, 2'h3));
  endtask

  task automatic t_cont();
    wr(ADDR_MODE, 8'h0B);
    wr(ADDR_CHAN, 8'h81);
    seen.delete();
    wr(ADDR_START, 8'h9E);
    for (int k = 0; k < 1000 && seen.size() < 5; k++) @(negedge ref_clk);
    if (seen.size() < 5) begin
      check("cont wait", 8'h00, 8'h01);
      conclude();
    end
    for (int k = 0; k < 5; k++) begin
      check("cont", {5'h0, seen[k]}, k[0] ? 8'h00 : 8'h07);
    end
    check("cont irq", {7'h0, irq_n_oe_q}, 8'h00);
    wr(ADDR_START, 8'h00);
    repeat (2 * lat) @(negedge ref_clk);
    n = seen.size();
    repeat (100) @(negedge ref_clk);
    check("stopped", {7'h0, conv_clk_en_q}, 8'h00);
    check("no start", 8'(seen.size() - n), 8'h00);
    rd(ADDR_STATUS, 1);
    check("cont acc", rx(0) & 8'h40, 8'h40);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_scan();
    t_single();
    t_overrun();
    t_cont();
    conclude();
  end
endmodule // adcss_seq_tb
